// *** hdl/mdms_defs.vh ***
// Purpose: Constants for the motor drive mode sequencer.
// Assumes: 50 MHz clock, one cycle per 20 ns.
// Notes: Times are kept in their own unit and converted to cycles here.
`ifndef MDMS_DEFS_VH
`define MDMS_DEFS_VH

`define MDMS_CLK_HZ 50000000
// Least time the standby condition must hold, in ms.
`define MDMS_STANDBY_INPUT_HOLD_MS 100
`define MDMS_STANDBY_INPUT_HOLD_CYC ((`MDMS_CLK_HZ / 1000) * `MDMS_STANDBY_INPUT_HOLD_MS)
// Default brake sequence time, in ms.
`define MDMS_BRAKE_MS 1000
`define MDMS_BRAKE_CYC ((`MDMS_CLK_HZ / 1000) * `MDMS_BRAKE_MS)
// Default automatic restart time after an error, in ms.
`define MDMS_RESTART_MS 1000
`define MDMS_RESTART_CYC ((`MDMS_CLK_HZ / 1000) * `MDMS_RESTART_MS)
// Counter width wide enough for all of the counts above.
`define MDMS_CNT_W 32
// Reset value of the one-hot state register (power-on state).
`define MDMS_ST_RST 7'h01
// Reset value of both synchroniser stages: every input reads low.
`define MDMS_SYNC_RST 4'h0

`endif

// *** hdl/mdms_timer.v ***
// Purpose: Loadable down counter that flags when a delay has run out.
// Assumes: Load takes priority over counting.
// Notes: Done is high once the count reaches zero and stays high until the next load.
`timescale 1ns/100ps
`include "mdms_defs.vh"

module mdms_timer (
  input wire clk,
  input wire rst_n,
  input wire load,
  input wire [`MDMS_CNT_W-1:0] load_val,
  output wire done
);

  reg [`MDMS_CNT_W-1:0] cnt_q;

  // Count down toward zero, reload on request.
  always @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= {`MDMS_CNT_W{1'b0}};
    end else if (load) begin
      cnt_q <= load_val;
    end else if (cnt_q != {`MDMS_CNT_W{1'b0}}) begin
      cnt_q <= cnt_q - {{(`MDMS_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Done while the counter rests at zero and no load is pending.
  assign done = (cnt_q == {`MDMS_CNT_W{1'b0}}) && !load;

endmodule

// *** hdl/mdms_top.v ***
// Purpose: Operating-mode sequencer of a sensorless motor predriver.
// Assumes: Speed command and fault inputs come from other clock domains.
// Notes: Long delays are parameters so a simulation can shorten them.
`timescale 1ns/100ps
`include "mdms_defs.vh"

////////////////////////////////////////////////////////////////////////
// Operation
// - Load settings from store before motor activity.
// - After loading, brake then enter idle.
// - Speed command present starts startup sequence.
// - Speed command withdrawn stops motor drive.
// - Fault enters error, restarts after restart time.
// - Error with zero command goes to idle.
// - Standby turns every output pin off.
// - Entering standby clears all latched errors.
// - Select 0: standby on standby input low.
// - Select 1: standby needs input low, command zero.
// - Select 1: overrides set forbid standby entry.
// - Idle holds power transistors off, command starts.
module mdms_top #(
  parameter [`MDMS_CNT_W-1:0] STANDBY_INPUT_HOLD_CYC = `MDMS_STANDBY_INPUT_HOLD_CYC,
  parameter [`MDMS_CNT_W-1:0] BRAKE_CYC = `MDMS_BRAKE_CYC,
  parameter [`MDMS_CNT_W-1:0] RESTART_CYC = `MDMS_RESTART_CYC
) (
  input wire CLK,
  input wire RST_N,
  input wire STANDBY_INPUT,
  input wire SPEED_CMD,
  input wire FAULT,
  input wire STANDBY_CONDITION_SELECT,
  input wire FULL_OFF_OVERRIDE,
  input wire NEVER_STOP_OPTION,
  input wire SPEED_COMMAND_INVERT,
  input wire STORE_LOAD_DONE,
  output reg STORE_LOAD_REQ,
  output reg PARAMS_VALID,
  output reg BRAKE_ON,
  output reg STARTUP_ON,
  output reg DRIVE_ON,
  output reg OUTPUT_ENABLE,
  output reg ERROR_FLAG,
  output reg STANDBY_ACTIVE,
  output reg [6:0] MODE
);

  // One-hot states.
  localparam [6:0] ST_PWRUP = 7'h01;
  localparam [6:0] ST_LOAD = 7'h02;
  localparam [6:0] ST_BRAKE = 7'h04;
  localparam [6:0] ST_IDLE = 7'h08;
  localparam [6:0] ST_RUN = 7'h10;
  localparam [6:0] ST_ERROR = 7'h20;
  localparam [6:0] ST_STANDBY_INPUT = 7'h40;

  //////////////////////////////////////////////////////////////////////
  // Input synchronisers: two flops per asynchronous input.
  reg [3:0] sync1_q;
  reg [3:0] sync2_q;
  wire [3:0] raw_in;
  assign raw_in = {STORE_LOAD_DONE, FAULT, SPEED_CMD, STANDBY_INPUT};

  // Only the second stage is read by logic. Reset reads load as not done,
  // so a stale stage cannot skip the load, and the pin as low, which only
  // keeps power-up waiting since standby is ignored there.
  always @(posedge CLK) begin
    if (!RST_N) begin
      sync1_q <= `MDMS_SYNC_RST;
      sync2_q <= `MDMS_SYNC_RST;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  wire standby_input_pin_s = sync2_q[0];
  wire spd_s = sync2_q[1];
  wire fault_s = sync2_q[2];
  wire load_done_s = sync2_q[3];

  //////////////////////////////////////////////////////////////////////
  // Standby condition decode.
  function standby_input_cond;
    input pin_low;
    input sel;
    input spd;
    input ovr;
    begin
      if (!sel) begin
        standby_input_cond = pin_low;
      end else begin
        standby_input_cond = pin_low && !spd && !ovr;
      end
    end
  endfunction

  wire overrides = FULL_OFF_OVERRIDE | NEVER_STOP_OPTION |
    SPEED_COMMAND_INVERT;
  wire cond_now = standby_input_cond(!standby_input_pin_s, STANDBY_CONDITION_SELECT, spd_s,
    overrides);

  //////////////////////////////////////////////////////////////////////
  // Qualification timer: condition must hold steadily before entry.
  reg [6:0] state_q;
  reg [6:0] state_d;
  reg cond_q;
  wire qual_done;

  // Remember the last condition level to restart timing on a change.
  always @(posedge CLK) begin
    if (!RST_N) begin
      cond_q <= 1'b0;
    end else begin
      cond_q <= cond_now;
    end
  end

  mdms_timer u_qual (
    .clk(CLK),
    .rst_n(RST_N),
    .load(!cond_now || !cond_q),
    .load_val(STANDBY_INPUT_HOLD_CYC),
    .done(qual_done)
  );

  wire standby_input_go = cond_now && qual_done;

  //////////////////////////////////////////////////////////////////////
  // Shared state timer for brake and restart delays.
  reg tmr_load;
  reg [`MDMS_CNT_W-1:0] tmr_val;
  wire tmr_done;

  mdms_timer u_seq (
    .clk(CLK),
    .rst_n(RST_N),
    .load(tmr_load),
    .load_val(tmr_val),
    .done(tmr_done)
  );

  //////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always @* begin
    state_d = state_q;
    tmr_load = 1'b0;
    tmr_val = BRAKE_CYC;
    case (state_q)
      ST_PWRUP: begin
        if (standby_input_pin_s) begin
          state_d = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (load_done_s) begin
          state_d = ST_BRAKE;
          tmr_load = 1'b1;
        end
      end
      ST_BRAKE: begin
        if (tmr_done) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (fault_s) begin
          state_d = ST_ERROR;
          tmr_load = 1'b1;
          tmr_val = RESTART_CYC;
        end else if (spd_s) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (fault_s) begin
          state_d = ST_ERROR;
          tmr_load = 1'b1;
          tmr_val = RESTART_CYC;
        end else if (!spd_s) begin
          state_d = ST_IDLE;
        end
      end
      ST_ERROR: begin
        if (!spd_s) begin
          state_d = ST_IDLE;
        end else if (tmr_done && !fault_s) begin
          state_d = ST_RUN;
        end
      end
      ST_STANDBY_INPUT: begin
        if (standby_input_pin_s) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_PWRUP;
      end
    endcase
    // Standby entry overrides every operating state once loaded.
    if (standby_input_go && state_q != ST_PWRUP && state_q != ST_LOAD) begin
      state_d = ST_STANDBY_INPUT;
    end
  end

  // State register.
  always @(posedge CLK) begin
    if (!RST_N) begin
      state_q <= `MDMS_ST_RST;
    end else begin
      state_q <= state_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Registered outputs, decoded from the next state; PARAMS_VALID sets on the load handshake and then holds.
  always @(posedge CLK) begin
    if (!RST_N) begin
      STORE_LOAD_REQ <= 1'b0;
      PARAMS_VALID <= 1'b0;
      BRAKE_ON <= 1'b0;
      STARTUP_ON <= 1'b0;
      DRIVE_ON <= 1'b0;
      OUTPUT_ENABLE <= 1'b0;
      ERROR_FLAG <= 1'b0;
      STANDBY_ACTIVE <= 1'b0;
      MODE <= `MDMS_ST_RST;
    end else begin
      STORE_LOAD_REQ <= (state_d == ST_LOAD);
      if (state_q == ST_LOAD && load_done_s) begin
        PARAMS_VALID <= 1'b1;
      end
      BRAKE_ON <= (state_d == ST_BRAKE);
      // Startup pulse marks entry into the run sequence.
      STARTUP_ON <= (state_d == ST_RUN) && (state_q != ST_RUN);
      DRIVE_ON <= (state_d == ST_RUN);
      // Pins are driven only in brake or run; off in idle and standby.
      OUTPUT_ENABLE <= (state_d == ST_RUN) ||
        (state_d == ST_BRAKE);
      if (state_d == ST_STANDBY_INPUT) begin
        ERROR_FLAG <= 1'b0;
      end else if (state_d == ST_ERROR) begin
        ERROR_FLAG <= 1'b1;
      end else if (state_d == ST_IDLE || state_d == ST_RUN) begin
        ERROR_FLAG <= 1'b0;
      end
      STANDBY_ACTIVE <= (state_d == ST_STANDBY_INPUT);
      MODE <= state_d;
    end
  end

endmodule

// *** tb/mdms_monitor.sv ***
// Purpose: Assertions on the mode sequencer ports.
// Assumes: One clock, synchronous active-low reset.
// Notes: Mode 08 is idle, 40 is standby.
`timescale 1ns/100ps
module mdms_monitor (
  input wire CLK,
  input wire RST_N,
  input wire SPEED_CMD,
  input wire PARAMS_VALID,
  input wire BRAKE_ON,
  input wire STARTUP_ON,
  input wire DRIVE_ON,
  input wire OUTPUT_ENABLE,
  input wire ERROR_FLAG,
  input wire STANDBY_ACTIVE,
  input wire [6:0] MODE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Run entry, and a command held off long enough to pass the syncs.
  sequence s_run_in; $rose(DRIVE_ON); endsequence
  sequence s_cmd_off; !SPEED_CMD [*4]; endsequence
  // Output relations per mode.
  property p_off; STANDBY_ACTIVE |-> !OUTPUT_ENABLE; endproperty
  a_off: assert property (p_off) else $error("standby drives");
  property p_clr; STANDBY_ACTIVE |-> !ERROR_FLAG; endproperty
  a_clr: assert property (p_clr) else $error("error kept");
  property p_idle; MODE == 7'h08 |-> !OUTPUT_ENABLE; endproperty
  a_idle: assert property (p_idle) else $error("idle drives");
  property p_load; OUTPUT_ENABLE |-> PARAMS_VALID; endproperty
  a_load: assert property (p_load) else $error("not loaded");
  property p_go; s_run_in |-> STARTUP_ON ##1 !STARTUP_ON; endproperty
  a_go: assert property (p_go) else $error("no startup");
  property p_brk; $fell(BRAKE_ON) |-> MODE[3] | MODE[6]; endproperty
  a_brk: assert property (p_brk) else $error("brake exit");
  property p_stop; s_cmd_off |=> !DRIVE_ON; endproperty
  a_stop: assert property (p_stop) else $error("still driving");
  property p_err; ERROR_FLAG |-> !OUTPUT_ENABLE; endproperty
  a_err: assert property (p_err) else $error("error drives");
endmodule
//////////////////////////////////////////////////////////////////////
bind mdms_top mdms_monitor u_mon (.CLK(CLK), .RST_N(RST_N),
  .SPEED_CMD(SPEED_CMD), .PARAMS_VALID(PARAMS_VALID), .BRAKE_ON(BRAKE_ON),
  .STARTUP_ON(STARTUP_ON), .DRIVE_ON(DRIVE_ON),
  .OUTPUT_ENABLE(OUTPUT_ENABLE), .ERROR_FLAG(ERROR_FLAG),
  .STANDBY_ACTIVE(STANDBY_ACTIVE), .MODE(MODE));

// *** tb/mdms_host_model.sv ***
// Purpose: Speed command source and standby pin driver.
// Assumes: Requests come from the bench.
// Notes: Pins change only at the rising edge.
`timescale 1ns/100ps
module mdms_host_model (
  input wire clk,
  input wire cmd_req,
  input wire standby_input_req,
  output reg SPEED_CMD = 1'h0,
  output reg STANDBY_INPUT = 1'h1
);
  // Standby stays low for as long as it is requested.
  always @(posedge clk) begin
    SPEED_CMD <= cmd_req;
    STANDBY_INPUT <= !standby_input_req;
  end
endmodule

// *** tb/tb_mdms_top.sv ***
// Purpose: Self-checking bench for the mode sequencer.
// Assumes: Delays shortened to 10, 20 and 30 cycles.
// Notes: Modes 02 load, 04 brake, 08 idle, 10 run, 20 error, 40 standby.
`timescale 1ns/100ps
module tb_mdms_top;
  reg clk, rst_n, cmd, standby_input, fault, sel, done;
  reg [2:0] ovr;
  wire spd, pin, pv, oe, err, slr, brk, drv, sa;
  wire [6:0] mode;
  integer miscompares, cmp_count, i;
  mdms_host_model host (.clk(clk), .cmd_req(cmd), .standby_input_req(standby_input),
    .SPEED_CMD(spd), .STANDBY_INPUT(pin));
  mdms_top #(.STANDBY_INPUT_HOLD_CYC(32'hA), .BRAKE_CYC(32'h14),
    .RESTART_CYC(32'h1E)) dut (.CLK(clk), .RST_N(rst_n),
    .STANDBY_INPUT(pin), .SPEED_CMD(spd), .FAULT(fault),
    .STANDBY_CONDITION_SELECT(sel), .FULL_OFF_OVERRIDE(ovr[0]),
    .NEVER_STOP_OPTION(ovr[1]), .SPEED_COMMAND_INVERT(ovr[2]),
    .STORE_LOAD_DONE(done), .STORE_LOAD_REQ(slr), .PARAMS_VALID(pv),
    .BRAKE_ON(brk), .STARTUP_ON(), .DRIVE_ON(drv), .OUTPUT_ENABLE(oe),
    .ERROR_FLAG(err), .STANDBY_ACTIVE(sa), .MODE(mode));
  // Compares one value and counts it.
  task chk(input [6:0] got, input [6:0] exp, input [31:0] nm);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("BAD %0s exp %h got %h", nm, exp, got);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task end_of_test;
    $display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Waits up to 200 cycles for a mode; a miss ends the run.
  task wm(input [6:0] m);
    for (i = 0; i < 200 && mode !== m; i = i + 1)
      @(negedge clk);
    chk(mode, m, "mode");
    if (mode !== m)
      end_of_test;
  endtask
  // Power-up load, brake, then idle.
  task t_power;
    wm(7'h02);
    chk({6'h0, pv}, 7'h0, "pv");
    chk({6'h0, slr}, 7'h1, "req");
    @(posedge clk) done <= 1'h1;
    wm(7'h04);
    chk({6'h0, pv}, 7'h1, "pv");
    chk({5'h0, brk, slr}, 7'h2, "bq");
    wm(7'h08);
    chk({6'h0, oe}, 7'h0, "oe");
  endtask
  // Start, fault with restart, then fault with command removed.
  task t_run;
    @(posedge clk) cmd <= 1'h1;
    wm(7'h10);
    chk({6'h0, drv}, 7'h1, "drv");
    @(posedge clk) fault <= 1'h1;
    wm(7'h20);
    chk({6'h0, err}, 7'h1, "err");
    @(posedge clk) fault <= 1'h0;
    repeat (10) @(negedge clk);
    chk(mode, 7'h20, "mode");
    wm(7'h10);
    @(posedge clk) fault <= 1'h1;
    wm(7'h20);
    @(posedge clk) cmd <= 1'h0;
    fault <= 1'h0;
    wm(7'h08);
    chk({6'h0, err}, 7'h0, "err");
  endtask
  // Select 0: short pulse ignored, long low enters standby from error.
  task t_stby0;
    @(posedge clk) cmd <= 1'h1;
    wm(7'h10);
    @(posedge clk) fault <= 1'h1;
    wm(7'h20);
    @(posedge clk) standby_input <= 1'h1;
    repeat (5) @(posedge clk);
    standby_input <= 1'h0;
    repeat (20) @(negedge clk);
    chk(mode, 7'h20, "mode");
    @(posedge clk) standby_input <= 1'h1;
    wm(7'h40);
    chk({5'h0, err, oe}, 7'h0, "eo");
    chk({6'h0, sa}, 7'h1, "sa");
    @(posedge clk) fault <= 1'h0;
    standby_input <= 1'h0;
    wm(7'h10);
  endtask
  // Select 1: a command or any override keeps standby out.
  task t_stby1;
    @(posedge clk) sel <= 1'h1;
    standby_input <= 1'h1;
    repeat (40) @(negedge clk);
    chk(mode, 7'h10, "mode");
    @(posedge clk) cmd <= 1'h0;
    wm(7'h40);
    @(posedge clk) standby_input <= 1'h0;
    wm(7'h08);
    repeat (3) begin
      @(posedge clk) ovr <= (ovr << 1) | {2'h0, ovr == 3'h0};
      standby_input <= 1'h1;
      repeat (40) @(negedge clk);
      chk(mode, 7'h08, "mode");
      @(posedge clk) standby_input <= 1'h0;
      repeat (5) @(posedge clk);
    end
  endtask
  // Clock of 20 ns.
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  // Reset for six cycles, then each scenario in turn.
  initial begin
    miscompares = 0;
    cmp_count = 0;
    {rst_n, cmd, standby_input, fault, sel, done, ovr} = 9'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    t_power;
    t_run;
    t_stby0;
    t_stby1;
    end_of_test;
  end
endmodule
